// ---- design/dcr_dual_clock_reset.sv ----
// Dual clock and reset unit with an AHB-Lite register slave.
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Main clock good after 16,384-cycle 14-bit delay.
// - Stop request presets main timer, oscillator off.
// - Release starts oscillator; zero halts, raises good.
// - Slow stop presets 6-bit timer, oscillator off.
// - Slow release counts down; zero raises good.
// - Prescaler: divide-by-two plus 8-bit divisor.
// - Prescaled slow clock is main/(2*(div+1)).
// - Mux picks prescaler or oscillator; reset prescaler.
// - Oscillator choice disables prescaler, needs toggling.
// - Dead slow oscillator keeps prescaler selected.
// - Power-on presets timer, asserts reset.
// - Timer zero releases reset unless pin low.
// - Power-on flag set by hardware, software clears.
// - Low reset pin holds internal reset.
// - Control bit 0 selects slow source, resets 0.
// - Slow divisor register resets to ff.
// - Low nibble divides first auxiliary clock.
// - High nibble divides second auxiliary clock.
// - Auxiliary divisor register resets to 00.
module dcr_dual_clock_reset (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        extResetPinB,
  input  wire logic        stopMainOsc,
  input  wire logic        stopSlowOsc,
  input  wire logic        slowOscIn,
  output logic             mainOscEnable,
  output logic             slowOscEnable,
  output logic             fastClockStable,
  output logic             slowClockStable,
  output logic             systemResetB,
  output logic             slowClockTick,
  output logic             slowFromOsc,
  output logic             auxClockTick1,
  output logic             auxClockTick2
);
  // Power-on is modelled by rst_b: all state takes constants here.
  logic [1:0]  pinSync;
  logic [1:0]  slowSync;
  logic        slowPrev;
  logic [7:0]  toggleCnt_reg;
  logic [7:0]  toggleCnt_next;
  logic        slowAlive_reg;
  logic        slowAlive_next;
  logic        selReg;
  logic        selNext;
  logic        porFlag_reg;
  logic        porFlag_next;
  logic [7:0]  slowDiv_reg;
  logic [7:0]  slowDiv_next;
  logic [7:0]  auxDiv_reg;
  logic [7:0]  auxDiv_next;
  logic        wrPend_reg;
  logic        wrPend_next;
  logic [7:0]  wrAddr_reg;
  logic [7:0]  wrAddr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  dcr_pkg::dcr_rst_type rstState_reg;
  dcr_pkg::dcr_rst_type rstState_next;
  logic        sysRstB_reg;
  logic        sysRstB_next;
  logic        useOsc_reg;
  logic        useOsc_next;
  logic        half_reg;
  logic        half_next;
  logic        slowTick_reg;
  logic        slowTick_next;
  logic        mainEn_reg;
  logic        slowEn_reg;
  logic        mainGood;
  logic        slowGood;
  logic        preTick;
  logic        aux1;
  logic        aux2;
  logic [13:0] mainCount;
  logic        addrPhase;

  function automatic logic [31:0] regRead(input logic [7:0] a,
                                          input logic s,
                                          input logic p,
                                          input logic [7:0] sd,
                                          input logic [7:0] ad,
                                          input logic [3:0] st);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      dcr_pkg::CTRL_ADDR:
      begin
        r[dcr_pkg::SEL_BIT] = s;
        r[dcr_pkg::POR_BIT] = p;
      end
      dcr_pkg::SLOWDIV_ADDR: r[7:0] = sd;
      dcr_pkg::AUXDIV_ADDR:  r[7:0] = ad;
      dcr_pkg::STATUS_ADDR:  r[3:0] = st;
      default:               r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Reset pin and slow oscillator come from outside the clock domain.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinSync  <= 2'h0;
      slowSync <= 2'h0;
      slowPrev <= 1'b0;
    end
    else
    begin
      pinSync  <= {pinSync[0], extResetPinB};
      slowSync <= {slowSync[0], slowOscIn};
      slowPrev <= slowSync[1];
    end
  end

  // The 14-bit timer is shared by power-on and main restart.
  dcr_startup_timer #(
    .W      (dcr_pkg::MAIN_TMR_W),
    .PRESET (dcr_pkg::MAIN_PRESET)
  ) uMainTimer (
    .clk   (clk),
    .rst_b (rst_b),
    .hold  (stopMainOsc),
    .count (mainCount),
    .good  (mainGood)
  );

  dcr_startup_timer #(
    .W      (dcr_pkg::SLOW_TMR_W),
    .PRESET (dcr_pkg::SLOW_PRESET)
  ) uSlowTimer (
    .clk   (clk),
    .rst_b (rst_b),
    .hold  (stopSlowOsc),
    .count (),
    .good  (slowGood)
  );

  // The prescaler halts while the oscillator is the source.
  dcr_clock_divider #(.W(8)) uPre (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (!useOsc_reg),
    .div   (slowDiv_reg),
    .tick  (preTick)
  );

  dcr_clock_divider #(.W(4)) uAux1 (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (1'b1),
    .div   (auxDiv_reg[3:0]),
    .tick  (aux1)
  );

  dcr_clock_divider #(.W(4)) uAux2 (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (1'b1),
    .div   (auxDiv_reg[7:4]),
    .tick  (aux2)
  );

  assign addrPhase = hsel && hready &&
                     (htrans == dcr_pkg::HTRANS_NONSEQ ||
                      htrans == dcr_pkg::HTRANS_SEQ);

  always_comb
  begin
    toggleCnt_next = toggleCnt_reg;
    slowAlive_next = slowAlive_reg;
    // A toggle must be seen within 256 cycles to count as running.
    if (slowSync[1] != slowPrev)
    begin
      toggleCnt_next = 8'h00;
      slowAlive_next = 1'b1;
    end
    else if (toggleCnt_reg == dcr_pkg::TOGGLE_LIMIT)
    begin
      slowAlive_next = 1'b0;
    end
    else
    begin
      toggleCnt_next = toggleCnt_reg + 8'h01;
    end
    // Source switch only with a live, stable oscillator.
    useOsc_next = selReg && slowAlive_reg && slowGood;
    half_next     = half_reg;
    slowTick_next = 1'b0;
    if (useOsc_reg)
    begin
      slowTick_next = slowSync[1] && !slowPrev;
    end
    else if (preTick)
    begin
      half_next     = !half_reg;
      slowTick_next = half_reg;
    end
  end

  always_comb
  begin
    rstState_next = rstState_reg;
    sysRstB_next  = 1'b0;
    case (rstState_reg)
      dcr_pkg::RST_POWER:
      begin
        if (mainCount == '0)
        begin
          rstState_next = dcr_pkg::RST_ACTIVE;
        end
      end
      dcr_pkg::RST_ACTIVE:
      begin
        if (pinSync[1])
        begin
          rstState_next = dcr_pkg::RST_RUN;
        end
      end
      dcr_pkg::RST_RUN:
      begin
        sysRstB_next = 1'b1;
        if (!pinSync[1])
        begin
          rstState_next = dcr_pkg::RST_ACTIVE;
          sysRstB_next  = 1'b0;
        end
      end
      default:
      begin
        rstState_next = dcr_pkg::RST_POWER;
      end
    endcase
  end

  always_comb
  begin
    selNext      = selReg;
    porFlag_next = porFlag_reg;
    slowDiv_next = slowDiv_reg;
    auxDiv_next  = auxDiv_reg;
    wrPend_next  = addrPhase && hwrite;
    wrAddr_next  = addrPhase ? haddr : wrAddr_reg;
    rdata_next   = rdata_reg;
    if (wrPend_reg)
    begin
      case (wrAddr_reg)
        dcr_pkg::CTRL_ADDR:
        begin
          selNext = hwdata[dcr_pkg::SEL_BIT];
          if (!hwdata[dcr_pkg::POR_BIT])
          begin
            porFlag_next = 1'b0;
          end
        end
        dcr_pkg::SLOWDIV_ADDR: slowDiv_next = hwdata[7:0];
        dcr_pkg::AUXDIV_ADDR:  auxDiv_next  = hwdata[7:0];
        default:               selNext      = selReg;
      endcase
    end
    if (addrPhase && !hwrite)
    begin
      rdata_next = regRead(haddr, selReg, porFlag_reg, slowDiv_reg,
                           auxDiv_reg,
                           {useOsc_reg, sysRstB_reg, slowGood, mainGood});
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      toggleCnt_reg <= 8'h00;
      slowAlive_reg <= 1'b0;
      useOsc_reg    <= 1'b0;
      half_reg      <= 1'b0;
      slowTick_reg  <= 1'b0;
      rstState_reg  <= dcr_pkg::RST_POWER;
      sysRstB_reg   <= 1'b0;
      selReg        <= dcr_pkg::CTRL_RESET[dcr_pkg::SEL_BIT];
      porFlag_reg   <= 1'b1;
      slowDiv_reg   <= dcr_pkg::SLOWDIV_RESET;
      auxDiv_reg    <= dcr_pkg::AUXDIV_RESET;
      wrPend_reg    <= 1'b0;
      wrAddr_reg    <= 8'h00;
      rdata_reg     <= 32'h0000_0000;
      mainEn_reg    <= 1'b0;
      slowEn_reg    <= 1'b0;
    end
    else
    begin
      toggleCnt_reg <= toggleCnt_next;
      slowAlive_reg <= slowAlive_next;
      useOsc_reg    <= useOsc_next;
      half_reg      <= half_next;
      slowTick_reg  <= slowTick_next;
      rstState_reg  <= rstState_next;
      sysRstB_reg   <= sysRstB_next;
      selReg        <= selNext;
      porFlag_reg   <= porFlag_next;
      slowDiv_reg   <= slowDiv_next;
      auxDiv_reg    <= auxDiv_next;
      wrPend_reg    <= wrPend_next;
      wrAddr_reg    <= wrAddr_next;
      rdata_reg     <= rdata_next;
      mainEn_reg    <= !stopMainOsc;
      slowEn_reg    <= !stopSlowOsc;
    end
  end

  // Good flags come straight from the timer flops.
  assign fastClockStable = mainGood;
  assign slowClockStable = slowGood;
  assign mainOscEnable   = mainEn_reg;
  assign slowOscEnable   = slowEn_reg;
  assign systemResetB    = sysRstB_reg;
  assign slowClockTick   = slowTick_reg;
  assign slowFromOsc     = useOsc_reg;
  assign auxClockTick1   = aux1;
  assign auxClockTick2   = aux2;
  assign hrdata          = rdata_reg;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
endmodule
`default_nettype wire

// ---- pkg/dcr_pkg.sv ----
// Constants, register map and state type of the dual clock and reset unit.
`default_nettype none
package dcr_pkg;
  localparam logic [7:0]  CTRL_ADDR       = 8'h00;
  localparam logic [7:0]  SLOWDIV_ADDR    = 8'h04;
  localparam logic [7:0]  AUXDIV_ADDR     = 8'h08;
  localparam logic [7:0]  STATUS_ADDR     = 8'h0c;
  localparam int          SEL_BIT         = 0;
  localparam int          POR_BIT         = 1;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  SLOWDIV_RESET   = 8'hff;
  localparam logic [7:0]  AUXDIV_RESET    = 8'h00;
  localparam int          MAIN_TMR_W      = 14;
  localparam logic [13:0] MAIN_PRESET     = 14'h3fff;
  localparam int          SLOW_TMR_W      = 6;
  localparam logic [5:0]  SLOW_PRESET     = 6'h3f;
  localparam int          TOGGLE_W        = 8;
  localparam logic [7:0]  TOGGLE_LIMIT    = 8'hff;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
  typedef enum logic [1:0] {RST_POWER, RST_ACTIVE, RST_RUN} dcr_rst_type;
endpackage
`default_nettype wire

// ---- design/dcr_startup_timer.sv ----
// Start-up down-counter that reports a stable clock after its preset expires.
`timescale 1ns/1ps
`default_nettype none
module dcr_startup_timer #(
  parameter int          W      = 14,
  parameter logic [W-1:0] PRESET = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         hold,
  output logic [W-1:0]      count,
  output logic              good
);
  logic [W-1:0] countReg;
  logic [W-1:0] countNext;
  logic         goodReg;
  logic         goodNext;

  always_comb
  begin
    countNext = countReg;
    goodNext  = goodReg;
    if (hold)
    begin
      countNext = PRESET;
      goodNext  = 1'b0;
    end
    else if (countReg != '0)
    begin
      countNext = countReg - 1'b1;
      goodNext  = 1'b0;
    end
    else
    begin
      goodNext = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      countReg <= PRESET;
      goodReg  <= 1'b0;
    end
    else
    begin
      countReg <= countNext;
      goodReg  <= goodNext;
    end
  end

  assign count = countReg;
  assign good  = goodReg;
endmodule
`default_nettype wire

// ---- design/dcr_clock_divider.sv ----
// Programmable divider producing a one-cycle enable every (div+1) cycles.
`timescale 1ns/1ps
`default_nettype none
module dcr_clock_divider #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  logic [W-1:0] cntReg;
  logic [W-1:0] cntNext;
  logic         tickReg;
  logic         tickNext;

  always_comb
  begin
    cntNext  = cntReg;
    tickNext = 1'b0;
    if (!run)
    begin
      cntNext = '0;
    end
    else if (cntReg >= div)
    begin
      cntNext  = '0;
      tickNext = 1'b1;
    end
    else
    begin
      cntNext = cntReg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cntReg  <= '0;
      tickReg <= 1'b0;
    end
    else
    begin
      cntReg  <= cntNext;
      tickReg <= tickNext;
    end
  end

  assign tick = tickReg;
endmodule
`default_nettype wire

// ---- bench/dcr_monitor.sv ----
// Checker of stop, start-up and reset behaviour at the unit's pins.
`timescale 1ns/1ps
`default_nettype none
module dcr_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic extResetPinB,
  input wire logic stopMainOsc,
  input wire logic stopSlowOsc,
  input wire logic mainOscEnable,
  input wire logic fastClockStable,
  input wire logic slowClockStable,
  input wire logic systemResetB,
  input wire logic slowFromOsc
);
  logic [14:0] pcnt_reg, pcnt_next, mcnt_reg, mcnt_next;
  // Both counters saturate so a long run cannot wrap them back to zero.
  always_comb
  begin
    pcnt_next = pcnt_reg + {14'h0, ~&pcnt_reg};
    mcnt_next = stopMainOsc ? 15'h0 : mcnt_reg + {14'h0, ~&mcnt_reg};
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      pcnt_reg <= 15'h0;
      mcnt_reg <= 15'h0;
    end
    else
    begin
      pcnt_reg <= pcnt_next;
      mcnt_reg <= mcnt_next;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  stop_main_a: assert property (stopMainOsc |=> !fastClockStable)
    else $error("main good while stopped");
  main_off_a: assert property (stopMainOsc |=> !mainOscEnable)
    else $error("main oscillator runs while stopped");
  main_on_a: assert property ($fell(stopMainOsc) |=> mainOscEnable)
    else $error("main oscillator did not start");
  main_delay_a: assert property ($rose(fastClockStable) |->
    mcnt_reg >= 15'h3ffc && mcnt_reg <= 15'h4006)
    else $error("main good at wrong count");
  stop_slow_a: assert property (stopSlowOsc |=> !slowClockStable)
    else $error("slow good while stopped");
  slow_delay_a: assert property ($fell(stopSlowOsc) |=>
    !slowClockStable [*8] ##[50:60] slowClockStable)
    else $error("slow good at wrong time");
  pin_reset_a: assert property (!extResetPinB [*5] |-> !systemResetB)
    else $error("reset released while pin low");
  reset_rel_a: assert property (systemResetB |-> pcnt_reg >= 15'h4000)
    else $error("reset released before count expired");
  osc_src_a: assert property (slowFromOsc |-> slowClockStable)
    else $error("oscillator source without stable clock");
endmodule
bind dcr_dual_clock_reset dcr_monitor mon (.clk, .rst_b, .extResetPinB,
  .stopMainOsc, .stopSlowOsc, .mainOscEnable, .fastClockStable,
  .slowClockStable, .systemResetB, .slowFromOsc);
`default_nettype wire

// ---- bench/dcr_power_model.sv ----
// Power manager model driving stop requests and the slow crystal pin.
`timescale 1ns/1ps
`default_nettype none
module dcr_power_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic stopMainReq,
  input  wire logic stopSlowReq,
  input  wire logic oscRun,
  input  wire logic slowOscEnable,
  input  wire logic fastClockStable,
  output logic      stopMainOsc,
  output logic      stopSlowOsc,
  output logic      slowOscIn,
  output logic      modeOk
);
  logic [2:0] phase;
  // A mode that needs the main clock waits for its stable flag.
  assign modeOk = fastClockStable && !stopMainOsc;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      stopMainOsc <= 1'b0;
      stopSlowOsc <= 1'b0;
      slowOscIn <= 1'b0;
      phase <= 3'h0;
    end
    else
    begin
      stopMainOsc <= stopMainReq;
      stopSlowOsc <= stopSlowReq;
      phase <= phase + 3'h1;
      // A crystal that is disabled or absent sits low instead of toggling.
      if (phase == 3'h7)
        slowOscIn <= oscRun && slowOscEnable && !slowOscIn;
    end
endmodule
`default_nettype wire

// ---- bench/dual_clock_reset_unit_bench.sv ----
// Self-checking bench for the dual clock and reset unit.
`timescale 1ns/1ps
`default_nettype none
module dual_clock_reset_unit_bench;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} dcr_row_type;
  localparam dcr_row_type ROWS [13] = '{'{1'b0, 8'h00, 8'h02},
    '{1'b0, 8'h04, 8'hff}, '{1'b0, 8'h08, 8'h00}, '{1'b1, 8'h04, 8'h03},
    '{1'b0, 8'h04, 8'h03}, '{1'b1, 8'h08, 8'h21}, '{1'b0, 8'h08, 8'h21},
    '{1'b1, 8'h00, 8'h00}, '{1'b0, 8'h00, 8'h00}, '{1'b1, 8'h00, 8'h02},
    '{1'b0, 8'h00, 8'h00}, '{1'b1, 8'h10, 8'h5a}, '{1'b0, 8'h10, 8'h00}};
  // The prescaled rate ceiling scales with the real main clock; at this
  // fast bench clock no divisor meets it, so only the ratios are checked.
  localparam logic [7:0] DIVS [3] = '{8'h00, 8'h03, 8'hff};
  logic        clk, rst_b, hsel, hwrite, extResetPinB, hreadyout, hresp;
  logic        stopMainReq, stopSlowReq, oscRun, stopMainOsc, stopSlowOsc;
  logic        slowOscIn, mainOscEnable, slowOscEnable, fastClockStable;
  logic        slowClockStable, systemResetB, slowClockTick, slowFromOsc;
  logic        auxClockTick1, auxClockTick2, modeOk;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  haddr;
  logic [31:0] hwdata, hrdata, r;
  int          error_cnt, comparisons, n, cyc;
  dcr_dual_clock_reset dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .extResetPinB, .stopMainOsc, .stopSlowOsc, .slowOscIn, .mainOscEnable,
    .slowOscEnable, .fastClockStable, .slowClockStable, .systemResetB,
    .slowClockTick, .slowFromOsc, .auxClockTick1, .auxClockTick2);
  dcr_power_model pm (.clk, .rst_b, .stopMainReq, .stopSlowReq, .oscRun,
    .slowOscEnable, .fastClockStable, .stopMainOsc, .stopSlowOsc,
    .slowOscIn, .modeOk);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst_b ? cyc + 1 : 0;
  task automatic stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic flag(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= dcr_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    flag(hresp, 1'b0);
  endtask
  function automatic logic pick(input int k);
    pick = k == 0 ? slowClockTick : k == 1 ? auxClockTick1 : auxClockTick2;
  endfunction
  // The first span after a divisor change may be cut short, so callers
  // measure twice and judge the second.
  task automatic span(input int k, output int m);
    while (pick(k) !== 1'b1) @(posedge clk);
    @(posedge clk);
    m = 1;
    while (pick(k) !== 1'b1)
    begin
      @(posedge clk);
      m++;
    end
  endtask
  initial
  begin
    #(4 * 70000);
    error_cnt++;
    stop_test();
  end
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    {rst_b, hsel, hwrite, stopMainReq, stopSlowReq, oscRun} = 6'h0;
    {haddr, htrans, hwdata, extResetPinB} = 43'h1;
    hsize = 3'h2;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ROWS[i])
    begin
      bus(ROWS[i].w, ROWS[i].a, {24'h0, ROWS[i].d}, r);
      if (!ROWS[i].w) chk(r, {24'h0, ROWS[i].d});
    end
    flag(systemResetB, 1'b0);
    while (systemResetB !== 1'b1 && cyc < 20000) @(posedge clk);
    flag(cyc >= 16384 && cyc <= 16400, 1'b1);
    bus(1'b0, dcr_pkg::STATUS_ADDR, 32'h0, r);
    chk(r, 32'h7);
    foreach (DIVS[i])
    begin
      bus(1'b1, dcr_pkg::SLOWDIV_ADDR, {24'h0, DIVS[i]}, r);
      span(0, n);
      span(0, n);
      chk(n, 2 * (DIVS[i] + 1));
    end
    span(1, n);
    span(1, n);
    chk(n, 32'h2);
    span(2, n);
    span(2, n);
    chk(n, 32'h3);
    bus(1'b1, dcr_pkg::CTRL_ADDR, 32'h1, r);
    repeat (300) @(posedge clk);
    flag(slowFromOsc, 1'b0);
    oscRun <= 1'b1;
    for (n = 0; n < 600 && slowFromOsc !== 1'b1; n++) @(posedge clk);
    flag(slowFromOsc, 1'b1);
    span(0, n);
    span(0, n);
    chk(n, 32'h10);
    oscRun <= 1'b0;
    for (n = 0; n < 600 && slowFromOsc !== 1'b0; n++) @(posedge clk);
    flag(slowFromOsc, 1'b0);
    bus(1'b1, dcr_pkg::CTRL_ADDR, 32'h0, r);
    stopMainReq <= 1'b1;
    repeat (4) @(posedge clk);
    flag(mainOscEnable, 1'b0);
    bus(1'b0, dcr_pkg::STATUS_ADDR, 32'h0, r);
    chk(r, 32'h6);
    stopMainReq <= 1'b0;
    for (n = 0; n < 17000 && modeOk !== 1'b1; n++) @(posedge clk);
    flag(n >= 16383 && n <= 16392, 1'b1);
    stopSlowReq <= 1'b1;
    repeat (4) @(posedge clk);
    flag(slowClockStable, 1'b0);
    flag(slowOscEnable, 1'b0);
    stopSlowReq <= 1'b0;
    for (n = 0; n < 100 && slowClockStable !== 1'b1; n++) @(posedge clk);
    flag(n >= 58 && n <= 70, 1'b1);
    extResetPinB <= 1'b0;
    repeat (20) @(posedge clk);
    flag(systemResetB, 1'b0);
    extResetPinB <= 1'b1;
    for (n = 0; n < 20 && systemResetB !== 1'b1; n++) @(posedge clk);
    flag(systemResetB, 1'b1);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, dcr_pkg::CTRL_ADDR, 32'h0, r);
    chk(r, 32'h2);
    stop_test();
  end
endmodule
`default_nettype wire
